// ### smr_receiver.sv
// synchronous master serial receiver with APB register access
// assumes an APB master on pclk and a slave transmitter on the shift clock
// What this block does
// - sync mode starts receiving when single or continuous enable is set
// - data line sampled at each falling edge of the generated shift clock
// - single enable alone receives one word, then stops
// - continuous enable receives words back to back until cleared
// - both enables set behaves as continuous reception
// - last bit moves the shift register into the FIFO when room
// - a word entering the FIFO sets the receive flag
// - receive interrupt raised only while its enable bit is set
// - receive flag read-only, cleared by hardware once FIFO read empty
// - FIFO holds two words while a third shifts in
// - full FIFO at last bit of third word sets overrun, word lost
// - overrun clears only when continuous enable is cleared
// - while overrun is set, no word enters the FIFO
// - ninth bit and framing flag kept per entry, read advances them
// - clearing both enables or port enable resets the receive logic
`timescale 1ns/100ps
`include "smr_cfg.svh"

module smr_receiver (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data_pin,
  output logic shift_clk_o,
  output logic shift_clk_oe,
  output logic irq
);

  smr_pkg::smr_state_type st_r;
  smr_pkg::smr_state_type st_nxt;
  logic active;
  logic access;
  logic done;
  logic wr_en;
  logic pop;
  logic push;
  logic word_done;
  logic ovr_set;
  logic [8:0] new_shift;
  smr_pkg::smr_entry_type new_entry;

  function automatic logic [3:0] last_bit(input logic nine);
    last_bit = nine ? `SMR_LAST9 : `SMR_LAST8;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SMR_OFF_RCS) || (a == `SMR_OFF_FIFO) || (a == `SMR_OFF_MODE) ||
             (a == `SMR_OFF_BAUD) || (a == `SMR_OFF_FLAG) || (a == `SMR_OFF_IEN);
  endfunction

  function automatic logic [31:0] rd_word(input smr_pkg::smr_state_type s, input logic [7:0] a);
    logic [31:0] w;
    smr_pkg::smr_entry_type h;
    w = 32'h0;
    h = s.fifo[s.rd];
    case (a)
      `SMR_OFF_RCS: begin
        w[`SMR_B_PORT_EN] = s.port_en;
        w[`SMR_B_NINE] = s.nine;
        w[`SMR_B_SINGLE_EN] = s.single_en;
        w[`SMR_B_CONT_EN] = s.cont_en;
        // status bits belong to the head entry, so read them before the data
        w[`SMR_B_FRAME_ERR] = h.frame_err;
        w[`SMR_B_OVERRUN] = s.overrun;
        w[`SMR_B_BIT9] = h.b9;
      end
      `SMR_OFF_FIFO: w[7:0] = h.data;
      `SMR_OFF_MODE: begin
        w[`SMR_B_CLK_MASTER] = s.clk_master;
        w[`SMR_B_SYNC] = s.sync;
      end
      `SMR_OFF_BAUD: w[7:0] = s.baud;
      `SMR_OFF_FLAG: begin
        w[`SMR_B_RXF] = (s.count != 2'h0);
        w[`SMR_B_OVF] = s.ovf_evt;
      end
      `SMR_OFF_IEN: w[1:0] = s.ien;
      default: w = 32'h0;
    endcase
    rd_word = w;
  endfunction

  always_comb begin
    st_nxt = st_r;
    // two-stage synchroniser on the data pin
    st_nxt.d1 = serial_data_pin;
    st_nxt.d2 = st_r.d1;
    // receive gating
    // only sync master mode runs the shifter; slave and async paths live elsewhere
    active = st_r.port_en && st_r.sync && st_r.clk_master && (st_r.single_en || st_r.cont_en);
    access = psel && penable;
    done = access && st_r.pready;
    // one wait state so that read data comes from a flop
    st_nxt.pready = access && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (st_nxt.pready) begin
      st_nxt.prdata = pwrite ? 32'h0 : rd_word(st_r, paddr);
      st_nxt.pslverr = !mapped(paddr);
    end
    wr_en = done && pwrite && pstrb[0];
    // reading data pops the head entry
    pop = done && !pwrite && (paddr == `SMR_OFF_FIFO) && (st_r.count != 2'h0);
    if (wr_en) begin
      case (paddr)
        `SMR_OFF_RCS: begin
          // overrun and the status bits are read-only here
          st_nxt.port_en = pwdata[`SMR_B_PORT_EN];
          st_nxt.nine = pwdata[`SMR_B_NINE];
          st_nxt.single_en = pwdata[`SMR_B_SINGLE_EN];
          st_nxt.cont_en = pwdata[`SMR_B_CONT_EN];
        end
        `SMR_OFF_MODE: begin
          st_nxt.clk_master = pwdata[`SMR_B_CLK_MASTER];
          st_nxt.sync = pwdata[`SMR_B_SYNC];
        end
        `SMR_OFF_BAUD: st_nxt.baud = pwdata[7:0];
        `SMR_OFF_FLAG: st_nxt.ovf_evt = st_r.ovf_evt && !pwdata[`SMR_B_OVF];
        `SMR_OFF_IEN: st_nxt.ien = pwdata[1:0];
        default: st_nxt.ien = st_r.ien;
      endcase
    end
    // shift engine: clock idles low, data taken as the clock falls
    word_done = 1'b0;
    new_shift = {st_r.d2, st_r.shift[8:1]};
    if (st_r.nine) begin
      new_entry = {1'b0, new_shift[8], new_shift[7:0]};
    end else begin
      new_entry = {1'b0, 1'b0, new_shift[8:1]};
    end
    if (!active) begin
      st_nxt.phase = smr_pkg::SH_IDLE;
      st_nxt.clk = 1'b0;
      st_nxt.bitn = 4'h0;
      st_nxt.cnt = 8'h00;
    end else begin
      case (st_r.phase)
        smr_pkg::SH_IDLE: begin
          st_nxt.phase = smr_pkg::SH_HIGH;
          st_nxt.clk = 1'b1;
          st_nxt.cnt = st_r.baud;
        end
        smr_pkg::SH_HIGH: begin
          if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
          end else begin
            st_nxt.clk = 1'b0;
            st_nxt.shift = new_shift;
            st_nxt.cnt = st_r.baud;
            st_nxt.phase = smr_pkg::SH_LOW;
            if (st_r.bitn == last_bit(st_r.nine)) begin
              word_done = 1'b1;
              st_nxt.bitn = 4'h0;
              // single word ends itself; continuous wins
              if (!st_r.cont_en) begin
                st_nxt.single_en = 1'b0;
              end
            end else begin
              st_nxt.bitn = st_r.bitn + 4'h1;
            end
          end
        end
        smr_pkg::SH_LOW: begin
          if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
          end else if (st_nxt.single_en || st_nxt.cont_en) begin
            // next bit or next word follows at once
            st_nxt.clk = 1'b1;
            st_nxt.cnt = st_r.baud;
            st_nxt.phase = smr_pkg::SH_HIGH;
          end else begin
            st_nxt.phase = smr_pkg::SH_IDLE;
          end
        end
        default: st_nxt.phase = smr_pkg::SH_IDLE;
      endcase
    end
    // push only with room and no overrun
    push = word_done && !st_r.overrun && (st_r.count != 2'h2);
    // full FIFO loses the new word
    ovr_set = word_done && !st_r.overrun && (st_r.count == 2'h2);
    if (push) begin
      st_nxt.fifo[st_r.rd ^ st_r.count[0]] = new_entry;
    end
    // read advances to the next entry's status
    if (pop) begin
      st_nxt.rd = !st_r.rd;
    end
    st_nxt.count = st_r.count + {1'b0, push} - {1'b0, pop};
    // overrun held only while continuous enable stays set
    // recovery path: software drops the continuous enable, which also idles the shifter once single enable is clear
    st_nxt.overrun = ovr_set || (st_r.overrun && st_nxt.cont_en);
    st_nxt.ovf_evt = st_nxt.ovf_evt || ovr_set;
    // gate the flags with the enables
    st_nxt.irq = |({st_nxt.ovf_evt, st_nxt.count != 2'h0} & st_nxt.ien);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.phase <= smr_pkg::SH_IDLE;
      st_r.baud <= `SMR_RST_BAUD;
      st_r.ien <= `SMR_RST_IEN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign shift_clk_o = st_r.clk;
  assign irq = st_r.irq;

  // clock pin driven as master only while the port runs in sync master mode
  logic oe_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= st_nxt.port_en && st_nxt.sync && st_nxt.clk_master;
    end
  end
  assign shift_clk_oe = oe_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic hi_end;
  assign hi_end = active && (st_r.phase == smr_pkg::SH_HIGH) && (st_r.cnt == 8'h00);

  a_start_on_enable: assert property (
    active && (st_r.phase == smr_pkg::SH_IDLE) |=> st_r.clk && (st_r.phase == smr_pkg::SH_HIGH))
    else $error("reception did not start on enable");

  a_sample_falling: assert property (
    hi_end |=> !st_r.clk && (st_r.shift[8] == $past(st_r.d2)))
    else $error("data not taken at falling clock edge");

  a_single_stops: assert property (
    word_done && !st_r.cont_en |=> !st_r.single_en)
    else $error("single reception did not stop");

  a_both_continue: assert property (
    word_done && st_r.cont_en && !wr_en |=> st_r.cont_en && (st_r.single_en == $past(st_r.single_en)))
    else $error("continuous enable lost precedence");

  a_push_flag: assert property (
    word_done && !st_r.overrun && (st_r.count != 2'h2) && !pop
      |=> (st_r.count == $past(st_r.count) + 2'h1) ##0 st_r.count != 2'h0)
    else $error("received word did not reach the fifo");

  a_irq_gated: assert property (
    (st_r.ien == 2'h0) [*2] |-> !irq)
    else $error("interrupt raised while disabled");

  a_flag_clear: assert property (
    (st_r.count != 2'h0) ##1 (st_r.count == 2'h0) |-> $past(pop))
    else $error("receive flag cleared without a read");

  a_overrun_set: assert property (
    word_done && (st_r.count == 2'h2) && !pop |=> st_r.overrun && (st_r.count == 2'h2))
    else $error("overrun not flagged on full fifo");

  a_overrun_hold: assert property (
    (!st_r.cont_en && !word_done) ##1 !st_r.cont_en |-> !st_r.overrun)
    else $error("overrun survived cleared continuous enable");

  a_overrun_block: assert property (
    st_r.overrun && word_done && !pop |=> st_r.count == $past(st_r.count))
    else $error("word entered fifo during overrun");

  a_status_next: assert property (
    pop && (st_r.count == 2'h2) && !word_done |=> st_r.fifo[st_r.rd] == $past(st_r.fifo[!st_r.rd]))
    else $error("head status did not advance on read");

  a_inactive_reset: assert property (
    !active |=> (st_r.phase == smr_pkg::SH_IDLE) && (st_r.bitn == 4'h0) && !st_r.clk)
    else $error("receive logic not reset when disabled");

  a_clk_rate: assert property (
    $rose(st_r.clk) && (st_r.baud != 8'h00) && active ##1 active |-> st_r.clk)
    else $error("shift clock high phase too short");

  // timing of the checks below
  // - irq is registered from the next-state flags, so it changes on the same edge as them
  // - the output enable is registered from the next-state mode bits and
  //   therefore equals the current mode bits
  // - the shift register moves only at the end of a high phase; a word that
  //   finds the fifo full or the overrun flag set leaves the fifo untouched
  // - a divisor of zero gives a one-cycle high phase, which the slave cannot
  //   follow through the pin synchroniser; software is expected to avoid it

  a_irq_follows: assert property (
    (st_nxt.count != 2'h0) && st_nxt.ien[0] |=> irq)
    else $error("enabled receive flag did not raise the interrupt");

  a_irq_masked: assert property (
    (st_nxt.ien == 2'h0) |=> !irq)
    else $error("interrupt raised with every source masked");

  a_fifo_bound: assert property (
    st_r.count != 2'h3)
    else $error("fifo holds more than two words");

  a_flag_last_read: assert property (
    pop && (st_r.count == 2'h1) && !push |=> st_r.count == 2'h0)
    else $error("receive flag kept after the last word was read");

  a_clk_quiet: assert property (
    !active |=> !shift_clk_o)
    else $error("shift clock toggled while reception is off");

  a_oe_master: assert property (
    st_r.port_en && st_r.sync && st_r.clk_master |-> shift_clk_oe)
    else $error("clock pin not driven in master mode");

  a_word_width: assert property (
    word_done |-> st_r.bitn == last_bit(st_r.nine))
    else $error("word ended at the wrong bit count");

  a_cont_next: assert property (
    active && (st_r.phase == smr_pkg::SH_LOW) && (st_r.cnt == 8'h00) && st_nxt.cont_en |=> st_r.clk)
    else $error("continuous reception paused between bits");

  a_shift_hold: assert property (
    !hi_end |=> $stable(st_r.shift))
    else $error("data taken away from a falling clock edge");

  a_lost_word: assert property (
    ovr_set && !pop |=> st_r.fifo == $past(st_r.fifo))
    else $error("overrun word reached the fifo");

  c_single_word: cover property (word_done && st_r.single_en && !st_r.cont_en);
  c_two_words: cover property (word_done && st_r.cont_en ##[1:1000] word_done);
  c_nine_bit: cover property (push && st_r.nine);
  c_overrun: cover property (ovr_set);
  c_fifo_read: cover property (pop && (st_r.count == 2'h2));

endmodule

// ### smr_cfg.svh
// register offsets, bit positions and reset values of the receiver
// assumes an 8-bit APB byte address; each register is one aligned word
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH
`define SMR_OFF_RCS 8'h00
`define SMR_OFF_FIFO 8'h04
`define SMR_OFF_MODE 8'h08
`define SMR_OFF_BAUD 8'h0c
`define SMR_OFF_FLAG 8'h10
`define SMR_OFF_IEN 8'h14
`define SMR_B_PORT_EN 7
`define SMR_B_NINE 6
`define SMR_B_SINGLE_EN 5
`define SMR_B_CONT_EN 4
`define SMR_B_FRAME_ERR 2
`define SMR_B_OVERRUN 1
`define SMR_B_BIT9 0
`define SMR_B_CLK_MASTER 7
`define SMR_B_SYNC 4
`define SMR_B_RXF 0
`define SMR_B_OVF 1
`define SMR_RST_BAUD 8'h00
`define SMR_RST_IEN 2'h0
`define SMR_LAST8 4'h7
`define SMR_LAST9 4'h8
`endif

// ### smr_pkg.sv
// types of the synchronous master receiver
// constants live in smr_cfg.svh
package smr_pkg;
  typedef enum logic [1:0] {SH_IDLE, SH_HIGH, SH_LOW} smr_phase_type;
  typedef struct packed {
    logic frame_err;
    logic b9;
    logic [7:0] data;
  } smr_entry_type;
  typedef struct packed {
    smr_phase_type phase;
    logic port_en;
    logic nine;
    logic single_en;
    logic cont_en;
    logic clk_master;
    logic sync;
    logic [7:0] baud;
    logic [1:0] ien;
    logic ovf_evt;
    logic overrun;
    logic d1;
    logic d2;
    logic clk;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [8:0] shift;
    smr_entry_type [1:0] fifo;
    logic rd;
    logic [1:0] count;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smr_state_type;
endpackage

// ### smr_slave.sv
// behavioural slave transmitter answering the generated shift clock
// assumes the receiver samples at the falling shift clock edge, lsb first
`timescale 1ns/100ps
module smr_slave (
  input wire logic pclk,
  input wire logic shift_clk,
  input wire logic [3:0] nbits,
  output logic data
);
  logic [8:0] words[$];
  logic [8:0] cur = 9'h000;
  logic prev = 1'b0;
  int idx = 0;
  initial data = 1'b0;
  always @(posedge pclk) begin
    prev <= shift_clk;
    // next bit after each rising edge, lsb first
    if (shift_clk && !prev) begin
      if (idx == 0)
        cur = (words.size() > 0) ? words.pop_front() : 9'($urandom);
      data <= cur[idx];
      idx = (idx + 1 == int'(nbits)) ? 0 : idx + 1;
    end else if (!shift_clk && prev) begin
      // hold time over: flip so a late sample never looks valid
      data <= ~data;
    end
  end
endmodule

// ### sync_master_serial_receiver_bench.sv
// self-checking bench of the receiver with a queue model of the fifo
// assumes smr_receiver with an apb slave and smr_slave on the data pin
`timescale 1ns/100ps
`include "smr_cfg.svh"
module sync_master_serial_receiver_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sdata;
  logic shift_clk_o;
  logic shift_clk_oe;
  logic irq;
  logic [3:0] nbits = 4'h8;
  logic [31:0] rdat;
  logic rerr;
  logic [8:0] w[4];
  logic [8:0] exp_q[$];
  logic ovr = 1'b0;
  int err_total = 0;
  int n_checks = 0;
  int n;
  always #20 pclk = ~pclk;
  smr_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_data_pin(sdata), .shift_clk_o(shift_clk_o), .shift_clk_oe(shift_clk_oe), .irq(irq));
  smr_slave u_slave (.pclk(pclk), .shift_clk(shift_clk_o), .nbits(nbits), .data(sdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitbit(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while (rdat[b] !== 1'b1 && k < 300);
    chk({31'h0, rdat[b]}, 32'h1);
  endtask
  // fifo model: two entries, overrun blocks further pushes
  task automatic model_push(input logic [8:0] v);
    if (exp_q.size() < 2 && !ovr)
      exp_q.push_back(v);
    else
      ovr = 1'b1;
  endtask
  // status first, then data, so the ninth bit of the head is kept
  task automatic pop_check;
    logic [8:0] e;
    e = exp_q.pop_front();
    apb(1'b0, `SMR_OFF_RCS, 32'h0);
    chk({31'h0, rdat[`SMR_B_BIT9]}, {31'h0, e[8]});
    apb(1'b0, `SMR_OFF_FIFO, 32'h0);
    chk(rdat, {24'h0, e[7:0]});
  endtask
  initial begin
    void'($urandom(39));
    for (int i = 0; i < 4; i++)
      w[i] = 9'($urandom);
    w[0][8] = 1'b1;
    w[1][8] = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdat, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // divisor and mode before any enable
    // half period of 4 pclk: 320 ns link clock, and room for the pin synchroniser
    apb(1'b1, `SMR_OFF_BAUD, 32'h3);
    apb(1'b1, `SMR_OFF_MODE, 32'h90);
    apb(1'b1, `SMR_OFF_IEN, 32'h1);
    u_slave.words.push_back({1'b0, w[0][7:0]});
    model_push({1'b0, w[0][7:0]});
    apb(1'b1, `SMR_OFF_RCS, 32'ha0);
    // the enable flop settles on the same edge as the completing write; sample it one edge later
    @(posedge pclk);
    chk({31'h0, shift_clk_oe}, 32'h1);
    n = 0;
    while (shift_clk_o !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (shift_clk_o === 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'd4);
    waitbit(`SMR_OFF_FLAG, `SMR_B_RXF);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `SMR_OFF_RCS, 32'h0);
    chk(rdat, 32'h80);
    apb(1'b1, `SMR_OFF_IEN, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    pop_check();
    apb(1'b0, `SMR_OFF_FLAG, 32'h0);
    chk(rdat, 32'h0);
    nbits <= 4'h9;
    apb(1'b1, `SMR_OFF_IEN, 32'h1);
    for (int i = 0; i < 3; i++) begin
      u_slave.words.push_back(w[i]);
      model_push(w[i]);
    end
    apb(1'b1, `SMR_OFF_RCS, 32'hf0);
    waitbit(`SMR_OFF_RCS, `SMR_B_OVERRUN);
    repeat (60) @(posedge pclk);
    apb(1'b0, `SMR_OFF_FLAG, 32'h0);
    chk(rdat, {30'h0, ovr, 1'b1});
    apb(1'b1, `SMR_OFF_RCS, 32'hc0);
    apb(1'b0, `SMR_OFF_RCS, 32'h0);
    chk({31'h0, rdat[`SMR_B_OVERRUN]}, 32'h0);
    pop_check();
    pop_check();
    apb(1'b1, `SMR_OFF_FLAG, 32'h2);
    apb(1'b0, `SMR_OFF_FLAG, 32'h0);
    chk(rdat, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SMR_OFF_RCS, 32'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, shift_clk_oe}, 32'h0);
    u_slave.idx = 0;
    u_slave.words.push_back(w[3]);
    ovr = 1'b0;
    model_push(w[3]);
    apb(1'b1, `SMR_OFF_RCS, 32'he0);
    waitbit(`SMR_OFF_FLAG, `SMR_B_RXF);
    pop_check();
    summarize();
  end
endmodule
